// *** design/byte_bus_cycle_sequencer.sv ***
// Bus-master cycle sequencer for an asynchronous byte-wide external bus
// What this block does
// R1 - Word reads take two byte cycles, long words four, one strobe per cycle.
// R2 - Lowest address bit is driven so each cycle picks its own byte.
// R3 - At S0 of a read, space code is valid and read_not_write is high.
// R4 - Entering S1 of every cycle the address bus carries a valid address.
// R5 - Read: address strobe and byte strobe assert at the start of S2.
// R6 - No acknowledge or fault by end of S4 inserts whole-clock wait states.
// R7 - Legacy select in S4 turns the cycle into one paced by the slow clock.
// R8 - Addressed device drives its read data during S6.
// R9 - Read data captured entering S7, strobes negated, address released in S7 unless read-modify-write.
// R10 - Fault and legacy select sampled from S4 on; read data latched at S6 end.
// R11 - Cycles end in S7, or in S9 when fault arrives without acknowledge.
// R12 - Word writes take two byte write cycles, strobing once in each.
// R13 - At S0 of a write, space code valid and read_not_write back high.
// R14 - Write: address strobe asserts and read_not_write drops at S2.
// R15 - Write data leave high impedance and drive the bus during S3.
// R16 - Write: byte strobe asserts at S4, then await termination or legacy.
// R17 - Write end: strobes off entering S7, buses released, line high after S7.
// R18 - Read-modify-write keeps address strobe asserted across both portions.
// R19 - S8 to S11 of read-modify-write leave every bus signal unchanged.
// R20 - Write portion starts at S12 with space, address, strobe, direction held.
// R21 - Read-modify-write drops read_not_write at S14, drives data during S15.
// R22 - At S16 byte strobe asserts; waits and legacy handled as in S4.
// R23 - Strobes off entering S19; buses released and line high after S19.
// R24 - High byte strobe stays negated; upper data lines carry nothing useful.
// R25 - Space code stays valid the whole time address strobe is asserted.
// R26 - Addressed device drops acknowledge or fault as the strobes end.
// R27 - No bus hand-over between read and write portions of read-modify-write.
`timescale 1ns/1ns
module byte_bus_cycle_sequencer
    import byte_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic [1:0] req_size,
    input wire logic [2:0] req_space,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [OPND_W-1:0] req_wdata,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [OPND_W-1:0] rsp_data,
    output logic rsp_fault,
    output logic [2:0] space_code,
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output logic [DATA_W-1:0] data_hi_out,
    output logic read_not_write,
    output logic address_strobe_n,
    output logic low_byte_strobe_n,
    output logic byte_data_strobe_n,
    output logic high_byte_strobe_n,
    input wire logic transfer_ack_n,
    input wire logic bus_fault_in_n,
    input wire logic legacy_periph_select_n,
    output logic e_clk
);
    // Each state except IDLE and LEG lasts one sys_clk cycle, i.e. one half of a bus clock
    typedef enum logic [4:0] {
        IDLE, S0, S1, S2, S3, S4, SW, LEG, S5, S6, S7, FX8, FX9,
        S8, S9, S10, S11, S12, S13, S14, S15, S16, S17, S18, S19
    } bus_state_e;

    bus_state_e state_r;
    bus_state_e state_nxt;
    op_kind_e kind_r;
    logic [2:0] space_r;
    logic [ADDR_W-1:0] addr_r;
    logic [OPND_W-1:0] wdata_r;
    logic [OPND_W-1:0] rdsh_r;
    logic [DATA_W-1:0] dout_r;
    logic [2:0] rem_r;
    logic fault_r;
    logic wr_half_r;
    logic [4:0] e_cnt_r;

    // Pin synchronisers: four flops, level accepted once stages two and three agree
    wire [SYNC_W-1:0] sync_raw = {transfer_ack_n, bus_fault_in_n, legacy_periph_select_n, data_in};
    logic [SYNC_W-1:0] syn1_r;
    logic [SYNC_W-1:0] syn2_r;
    logic [SYNC_W-1:0] syn3_r;
    logic [SYNC_W-1:0] syn_r;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    syn1_r[gi] <= SYNC_RST[gi];
                    syn2_r[gi] <= SYNC_RST[gi];
                    syn3_r[gi] <= SYNC_RST[gi];
                    syn_r[gi] <= SYNC_RST[gi];
                end else if (ce) begin
                    syn1_r[gi] <= sync_raw[gi];
                    syn2_r[gi] <= syn1_r[gi];
                    syn3_r[gi] <= syn2_r[gi];
                    if (syn2_r[gi] == syn3_r[gi]) begin
                        syn_r[gi] <= syn3_r[gi];
                    end
                end
            end
        end
    endgenerate

    wire ack = !syn_r[SYN_ACK];
    wire flt = !syn_r[SYN_FLT];
    wire legacy_periph_select = !syn_r[SYN_VPA];
    wire [DATA_W-1:0] din = syn_r[DATA_W-1:0];

    // Free-running slow peripheral clock
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            e_cnt_r <= 5'h00;
        end else if (ce) begin
            e_cnt_r <= (e_cnt_r == E_LAST_HALF) ? 5'h00 : e_cnt_r + 5'h01;
        end
    end
    assign e_clk = (e_cnt_r >= E_LOW_HALVES);
    wire e_fall = (e_cnt_r == E_LAST_HALF);

    // Strobe window S4 to S6, without S16 to S18 which are decoded apart; wait and legacy states sit inside it
    function automatic logic in_term_win(bus_state_e s);
        return s inside {S4, SW, LEG, S5, S6};
    endfunction

    wire is_wr = (kind_r == OP_WRITE);
    wire is_rmw = (kind_r == OP_TAS);
    wire busy = (state_r != IDLE);
    wire term_hit = ack || flt;
    wire [RSP_W-1:0] rsp_word = {fault_r, rdsh_r};

    rsp_buf_if bi();

    // A new operation starts only with buffer room, so the final push never stalls
    assign req_ready = !busy && bi.in_ready;
    wire start = req_valid && req_ready;
    wire cyc_end = (state_r == FX9) || (state_r == S19)
        || (state_r == S7 && !fault_r && !(is_rmw && !wr_half_r));
    wire op_done = cyc_end && (fault_r || rem_r == BYTE_LAST);

    assign bi.in_valid = op_done;
    assign bi.in_data = rsp_word;
    assign bi.out_ready = rsp_ready;
    assign rsp_valid = bi.out_valid;
    assign rsp_data = bi.out_data[OPND_W-1:0];
    assign rsp_fault = bi.out_data[OPND_W];

    rsp_buf2 u_buf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .bi(bi.store)
    );

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IDLE: state_nxt = start ? S0 : IDLE;
            S0: state_nxt = S1;
            S1: state_nxt = S2;
            S2: state_nxt = S3;
            S3: state_nxt = S4;
            S4, S16: begin
                if (term_hit) begin
                    state_nxt = (state_r == S16) ? S17 : S5;
                end else if (legacy_periph_select) begin
                    state_nxt = LEG; // R7 R22
                end else begin
                    state_nxt = SW; // R6 R22
                end
            end
            SW: state_nxt = wr_half_r ? S16 : S4; // R6
            LEG: begin
                if (e_fall) begin
                    state_nxt = wr_half_r ? S17 : S5; // R7
                end
            end
            S5: state_nxt = S6;
            S6: state_nxt = S7;
            S7: begin
                if (fault_r) begin
                    state_nxt = FX8; // R11
                end else if (is_rmw && !wr_half_r) begin
                    state_nxt = S8; // R27
                end else begin
                    state_nxt = op_done ? IDLE : S0;
                end
            end
            FX8: state_nxt = FX9;
            FX9: state_nxt = IDLE; // R11
            S8: state_nxt = S9;
            S9: state_nxt = S10;
            S10: state_nxt = S11;
            S11: state_nxt = S12;
            S12: state_nxt = S13;
            S13: state_nxt = S14;
            S14: state_nxt = S15;
            S15: state_nxt = S16;
            S17: state_nxt = S18;
            S18: state_nxt = S19;
            S19: state_nxt = IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Operation context: latched at start, advanced between byte cycles
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            kind_r <= OP_READ;
            space_r <= 3'h0;
            addr_r <= '0;
            wdata_r <= '0;
            rem_r <= 3'h0;
        end else if (ce) begin
            if (start) begin
                kind_r <= op_kind_e'(req_kind);
                space_r <= req_space; // R3 R13 R25
                addr_r <= req_addr;
                unique case (op_size_e'(req_size))
                    SZ_WORD: begin
                        rem_r <= BYTES_WORD; // R1 R12
                        wdata_r <= req_wdata << SHIFT_WORD;
                    end
                    SZ_LONG: begin
                        rem_r <= BYTES_LONG; // R1
                        wdata_r <= req_wdata;
                    end
                    default: begin
                        rem_r <= BYTES_BYTE;
                        wdata_r <= req_wdata << SHIFT_BYTE;
                    end
                endcase
            end else if (cyc_end && !op_done) begin
                addr_r <= addr_r + ADDR_W'(1); // R2
                wdata_r <= wdata_r << DATA_W;
                rem_r <= rem_r - 3'h1;
            end
        end
    end

    // Read assembly, fault capture and portion tracking
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdsh_r <= '0;
            fault_r <= 1'b0;
            wr_half_r <= 1'b0;
        end else if (ce) begin
            if (start) begin
                rdsh_r <= '0;
                fault_r <= 1'b0;
            end else if (state_r == S6 && !is_wr && !wr_half_r) begin
                rdsh_r <= {rdsh_r[OPND_W-DATA_W-1:0], din}; // R9 R10
            end
            if ((state_r == S4 || state_r == S16) && term_hit) begin
                fault_r <= flt && !ack; // R10 R11
            end
            if (state_r == S12) begin
                wr_half_r <= 1'b1; // R20
            end else if (cyc_end) begin
                wr_half_r <= 1'b0;
            end
        end
    end

    // Write byte is loaded before the bus is driven, so it is stable for the whole drive
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dout_r <= '0;
        end else if (ce) begin
            if (state_r == S2 && is_wr) begin
                dout_r <= wdata_r[OPND_W-1 -: DATA_W];
            end else if (state_r == S14) begin
                dout_r <= rdsh_r[DATA_W-1:0] | TAS_SET_MASK;
            end
        end
    end

    // Pin decode from the current half-clock state
    wire as_on = (state_r inside {S2, S3} || in_term_win(state_r)) // R5 R14
        || (is_rmw && state_r inside {S7, S8, S9, S10, S11, S12, S13, S14, S15,
        S16, S17, S18}); // R18 R19 R20
    wire ds_on = (!is_wr && state_r inside {S2, S3}) // R5
        || in_term_win(state_r) // R16
        || (state_r inside {S16, S17, S18}); // R22 R23
    wire rnw_low = (is_wr && state_r inside {S2, S3, S7}) // R14 R17
        || (is_wr && in_term_win(state_r))
        || (state_r inside {S14, S15, S16, S17, S18, S19}) // R21 R23
        || (wr_half_r && state_r inside {SW, LEG});
    wire a_on = state_r inside {S1, S2, S3} || in_term_win(state_r) // R4
        || ((is_wr || is_rmw) && state_r == S7) // R9 R17
        || state_r inside {S8, S9, S10, S11, S12, S13, S14, S15, S16, S17, S18, S19};
    wire d_on = (is_wr && (state_r inside {S3, S7} || in_term_win(state_r))) // R15 R17
        || state_r inside {S15, S16, S17, S18, S19} // R21 R23
        || (wr_half_r && state_r inside {SW, LEG});

    assign space_code = space_r; // R25
    assign addr_out = addr_r; // R2
    assign addr_oe = a_on;
    assign data_out = dout_r;
    assign data_oe = d_on;
    assign data_hi_out = '0; // R24
    assign read_not_write = !rnw_low; // R3 R13
    assign address_strobe_n = !as_on;
    assign low_byte_strobe_n = !ds_on;
    assign byte_data_strobe_n = !ds_on;
    assign high_byte_strobe_n = 1'b1; // R24

    // Checks
    default clocking cb @(posedge sys_clk iff ce); endclocking
    default disable iff (!nrst);

    sequence rd_lead_s;
        read_not_write ##1 addr_oe ##1 (!address_strobe_n && !low_byte_strobe_n);
    endsequence

    a_read_lead: assert property ((state_r == S0 && !is_wr) |-> rd_lead_s) // R3 R4 R5
        else $error("read cycle lead-in wrong");
    a_write_lead: assert property ((state_r == S1 && is_wr) |=> (!address_strobe_n // R14 R15 R16
        && !read_not_write && !data_oe && low_byte_strobe_n)
        ##1 (data_oe && data_out == $past(wdata_r[OPND_W-1 -: DATA_W], 2)) ##1 !low_byte_strobe_n)
        else $error("write cycle lead-in wrong");
    a_wait_whole: assert property ((state_r inside {S4, S16} && !ack && !flt && !legacy_periph_select) // R6
        |=> state_r == SW ##1 state_r inside {S4, S16})
        else $error("wait state not whole clock");
    a_legacy_turn: assert property ((state_r == S4 && !ack && !flt && legacy_periph_select) // R7
        |=> state_r == LEG && !low_byte_strobe_n)
        else $error("legacy select ignored");
    a_read_capture: assert property ((state_r == S6 && !is_wr && !wr_half_r) // R9 R10
        |=> rdsh_r[DATA_W-1:0] == $past(din) && address_strobe_n == !is_rmw && low_byte_strobe_n)
        else $error("read data not captured at S7");
    a_fault_ext: assert property ((state_r == S7 && fault_r) // R11
        |=> state_r == FX8 ##1 state_r == FX9 ##1 state_r == IDLE)
        else $error("faulted cycle not ended in S9");
    a_rmw_hold: assert property ((state_r == S7 && is_rmw && !fault_r) // R18 R19 R20
        |=> (!address_strobe_n && addr_oe && read_not_write && $stable(addr_out)) [*5])
        else $error("indivisible cycle released bus");
    a_rmw_write: assert property (state_r == S14 |-> !read_not_write // R21 R22
        ##1 (data_oe && data_out[DATA_W-1] && low_byte_strobe_n) ##1 !low_byte_strobe_n)
        else $error("modify write portion wrong");
    a_release: assert property ((state_r inside {S7, S19} && !fault_r // R17 R23
        && (is_wr || wr_half_r)) |-> low_byte_strobe_n
        ##1 (read_not_write && !data_oe && (state_r == S0 || !addr_oe)))
        else $error("write end release wrong");
    a_space_hold: assert property ((!address_strobe_n && !$past(address_strobe_n)) // R24 R25
        |-> $stable(space_code) && high_byte_strobe_n)
        else $error("space code moved under strobe");
    a_byte_count: assert property ((start && op_size_e'(req_size) == SZ_LONG) // R1
        |=> rem_r == BYTES_LONG)
        else $error("long operand byte count wrong");
endmodule // byte_bus_cycle_sequencer

// *** design/byte_bus_pkg.sv ***
// Shared constants and types for the byte-wide bus cycle sequencer
package byte_bus_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int OPND_W = 32;
    localparam int RSP_W = OPND_W + 1;
    localparam int BUF_DEPTH = 2;
    localparam int SYNC_W = DATA_W + 3;
    localparam int STAGE_W = 3;

    // Operation requested by the execution side
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_TAS} op_kind_e;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} op_size_e;

    localparam logic [2:0] BYTES_BYTE = 3'h1;
    localparam logic [2:0] BYTES_WORD = 3'h2;
    localparam logic [2:0] BYTES_LONG = 3'h4;
    localparam logic [2:0] BYTE_LAST = 3'h1;

    // Write operands leave most significant byte first
    localparam int SHIFT_BYTE = 24;
    localparam int SHIFT_WORD = 16;

    // Bit that the test-and-set modify step forces high
    localparam logic [7:0] TAS_SET_MASK = 8'h80;

    // Slow peripheral clock: ten bus clocks, six low and four high, in half-clock steps
    localparam logic [4:0] E_LOW_HALVES = 5'h0c;
    localparam logic [4:0] E_LAST_HALF = 5'h13;

    // Synchroniser reset: the three active-low controls idle high, data idles low
    localparam logic [SYNC_W-1:0] SYNC_RST = 11'h700;
    localparam int SYN_ACK = DATA_W + 2;
    localparam int SYN_FLT = DATA_W + 1;
    localparam int SYN_VPA = DATA_W;
endpackage

// *** design/rsp_buf2.sv ***
// Two-entry answer buffer; read data come straight from entry registers
`timescale 1ns/1ns
module rsp_buf2
    import byte_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    rsp_buf_if.store bi
);
    logic [RSP_W-1:0] mem_r [BUF_DEPTH];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    wire push = bi.in_valid && bi.in_ready;
    wire pop = bi.out_valid && bi.out_ready;

    assign bi.in_ready = (cnt_r != 2'(BUF_DEPTH));
    assign bi.out_valid = (cnt_r != 2'h0);
    assign bi.out_data = mem_r[rp_r];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else if (ce && push) begin
            mem_r[wp_r] <= bi.in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else if (ce) begin
            wp_r <= wp_r ^ push;
            rp_r <= rp_r ^ pop;
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end
endmodule // rsp_buf2

// *** design/rsp_buf_if.sv ***
// Valid/ready carrier between the sequencer and its answer buffer
`timescale 1ns/1ns
interface rsp_buf_if import byte_bus_pkg::*; ();
    logic in_valid;
    logic in_ready;
    logic [RSP_W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [RSP_W-1:0] out_data;

    modport store (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport feed (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data
    );
endinterface

// *** sim/bus_mem_model.sv ***
// Byte-wide memory that answers the sequencer's bus cycles
`timescale 1ns/1ns
module bus_mem_model
    import byte_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic read_not_write,
    input wire logic address_strobe_n,
    input wire logic low_byte_strobe_n,
    input wire logic [1:0] mode,
    input wire logic [3:0] delay,
    output logic [DATA_W-1:0] data_in,
    output logic transfer_ack_n,
    output logic bus_fault_in_n,
    output logic legacy_periph_select_n
);
    logic [7:0] mem [256];
    logic [7:0] last_r;
    logic [3:0] wait_r;
    wire sel = !address_strobe_n && !low_byte_strobe_n;
    wire answer = sel && (wait_r >= delay);
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
        last_r = 8'h00;
        wait_r = 4'h0;
    end
    always @(posedge sys_clk) begin
        wait_r <= !sel ? 4'h0 : (wait_r == 4'hf ? wait_r : wait_r + 4'h1);
        last_r <= data_in;
        if (sel && !read_not_write && data_oe) mem[addr_out[7:0]] <= data_out;
    end
    // A slow device has nothing valid before it answers; idle lines toggle
    assign data_in = (answer && read_not_write) ? mem[addr_out[7:0]] : ~last_r;
    // Every answer drops as soon as the strobes end
    assign transfer_ack_n = !(answer && (mode == 2'h0 || mode == 2'h3));
    assign bus_fault_in_n = !(answer && (mode == 2'h1 || mode == 2'h3));
    assign legacy_periph_select_n = !(answer && mode == 2'h2);
endmodule // bus_mem_model

// *** sim/testbench.sv ***
// Self-checking bench for the byte-wide bus cycle sequencer
`timescale 1ns/1ns
module testbench;
    import byte_bus_pkg::*;
    logic sys_clk = 0;
    logic nrst = 0;
    logic ce = 1;
    logic req_valid = 0;
    logic rsp_ready = 1;
    logic [1:0] req_kind = 0;
    logic [1:0] req_size = 0;
    logic [2:0] req_space = 0;
    logic [ADDR_W-1:0] req_addr = 0;
    logic [OPND_W-1:0] req_wdata = 0;
    logic [1:0] mode = 0;
    logic [3:0] delay = 0;
    wire req_ready, rsp_valid, rsp_fault, addr_oe, data_oe, read_not_write, e_clk;
    wire address_strobe_n, low_byte_strobe_n, byte_data_strobe_n, high_byte_strobe_n;
    wire transfer_ack_n, bus_fault_in_n, legacy_periph_select_n;
    wire [OPND_W-1:0] rsp_data;
    wire [2:0] space_code;
    wire [ADDR_W-1:0] addr_out;
    wire [DATA_W-1:0] data_in, data_out, data_hi_out;
    int num_errors = 0;
    int checks_done = 0;
    int nstb = 0;
    int nas = 0;
    logic [ADDR_W-1:0] addr_q [$];
    logic [OPND_W-1:0] got_data;
    logic got_fault;
    logic prev_stb = 1;
    logic prev_as = 1;

    byte_bus_cycle_sequencer i_dut (.*);
    bus_mem_model i_mem (.*);

    always #25 sys_clk = ~sys_clk;

    task automatic check(input logic [OPND_W-1:0] seen, input logic [OPND_W-1:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [7:0] ini(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction

    // Bus watcher: every byte strobe must come with a consistent bus
    always @(posedge sys_clk) begin
        prev_stb <= low_byte_strobe_n;
        prev_as <= address_strobe_n;
        if (prev_as === 1'b1 && address_strobe_n === 1'b0) nas++;
        if (prev_stb === 1'b1 && low_byte_strobe_n === 1'b0) begin
            addr_q.push_back(addr_out);
            check(addr_oe, 1, "address driven");
            check(address_strobe_n, 0, "address strobe");
            check(byte_data_strobe_n, 0, "data strobe");
            check(high_byte_strobe_n, 1, "high strobe");
            check(data_hi_out, 0, "upper data");
            check(space_code, req_space, "space code");
            check(read_not_write, !(req_kind == 1 || (req_kind == 2 && nstb == 1)), "dir");
            check(data_oe, !read_not_write, "data drive");
            nstb++;
        end
    end

    task automatic get_rsp();
        int n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1) && n < 2000);
        if (n >= 2000) begin
            num_errors++;
            summarize();
        end
        got_data = rsp_data;
        got_fault = rsp_fault;
    endtask

    task automatic run_op(input logic [1:0] k, input logic [1:0] s,
                          input logic [ADDR_W-1:0] a, input logic [OPND_W-1:0] w, input bit wr);
        int n = 0;
        @(posedge sys_clk);
        nstb = 0;
        nas = 0;
        addr_q.delete();
        req_valid <= 1'b1;
        req_kind <= k;
        req_size <= s;
        req_addr <= a;
        req_wdata <= w;
        req_space <= a[2:0] | 3'h1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        req_valid <= 1'b0;
        if (n >= 100) begin
            num_errors++;
            summarize();
        end
        if (wr) begin
            get_rsp();
            check({address_strobe_n, low_byte_strobe_n, read_not_write, addr_oe, data_oe},
                  5'b11100, "idle bus");
        end
    endtask

    task automatic chk_seq(input logic [ADDR_W-1:0] a, input int n);
        check(nstb, n, "strobe count");
        for (int i = 0; i < n; i++) check(addr_q[i], a + i, "byte address");
    endtask

    task automatic t_read();
        run_op(0, 2, 'h10, 0, 1);
        check(got_data, {ini('h10), ini('h11), ini('h12), ini('h13)}, "long read");
        chk_seq('h10, 4);
        check(got_fault, 0, "no fault");
        delay <= 4'h9;
        run_op(0, 1, 'h21, 0, 1);
        check(got_data, {ini('h21), ini('h22)}, "slow word read");
        chk_seq('h21, 2);
    endtask

    task automatic t_write();
        delay <= 4'h5;
        run_op(1, 1, 'h40, 32'h0000c3a5, 1);
        check({i_mem.mem[8'h40], i_mem.mem[8'h41]}, 16'hc3a5, "word write");
        chk_seq('h40, 2);
        run_op(0, 1, 'h40, 0, 1);
        check(got_data, 32'h0000c3a5, "read back");
    endtask

    task automatic t_tas();
        delay <= 4'h0;
        for (int i = 0; i < 2; i++) begin
            run_op(2, 0, 'h55, 0, 1);
            check(got_data, i ? 32'h8f : 32'h0f, "tas read");
            check(i_mem.mem[8'h55], 8'h8f, "tas write");
            check(nas, 1, "one address strobe");
            check(nstb, 2, "strobe count");
            check(addr_q[0], 'h55, "read address");
            check(addr_q[1], 'h55, "write address");
        end
    endtask

    task automatic t_end();
        int ehi = 0;
        logic ev;
        repeat (20) begin
            @(posedge sys_clk);
            ehi += e_clk;
        end
        check(ehi, 8, "slow clock duty");
        ce <= 1'b0;
        @(posedge sys_clk);
        ev = e_clk;
        ehi = 0;
        repeat (20) begin
            @(posedge sys_clk);
            ehi += (e_clk != ev);
        end
        ce <= 1'b1;
        check(ehi, 0, "enable freezes clock");
        mode <= 2'h1;
        run_op(0, 1, 'h60, 0, 1);
        check(got_fault, 1, "fault alone");
        check(nstb, 1, "stop at fault");
        mode <= 2'h3;
        run_op(0, 0, 'h61, 0, 1);
        check(got_fault, 0, "fault with ack");
        check(got_data, ini('h61), "data with ack");
        mode <= 2'h2;
        run_op(0, 0, 'h70, 0, 1);
        check(got_data, ini('h70), "legacy read");
        mode <= 2'h0;
    endtask

    task automatic t_buffer();
        rsp_ready <= 1'b0;
        run_op(0, 0, 'h80, 0, 0);
        run_op(0, 0, 'h81, 0, 0);
        // Long enough for the second answer to land, so only a full buffer holds ready low
        repeat (30) @(posedge sys_clk);
        check({req_ready, rsp_valid}, 2'b01, "buffer full");
        rsp_ready <= 1'b1;
        get_rsp();
        check(got_data, ini('h80), "first answer");
        get_rsp();
        check(got_data, ini('h81), "second answer");
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        check({req_ready, rsp_valid, address_strobe_n, low_byte_strobe_n, read_not_write,
               addr_oe, data_oe, high_byte_strobe_n, e_clk}, 9'h172, "reset state");
        nrst <= 1'b1;
        t_read();
        t_write();
        t_tas();
        t_end();
        t_buffer();
        summarize();
    end
endmodule // testbench
